// ### src/ioc_cell.sv
// How it works
// - the raw pad level goes straight to the core as a combinational input and as a clock, past every delay and flop.
// - an input delay can be a fixed tap, or on bottom-edge cells a tap picked at run time by a five-bit select.
// - in single-rate mode the pad data lands in one register on the system clock.
// - in dual-rate mode the pad is sampled on both clock edges by two registers, giving two streams.
// - the first captured output shows the rising sample, the second the falling sample or, single-rate, the registered input.
// - single-rate output enable from the core is held in one flop that drives the pad enable.
// - in memory mode a right-edge cell re-registers that enable on the shifted write strobe and uses it instead.
// - only right-edge cells listen to the shifted strobes and the read polarity; other cells ignore them.
// - on right-edge cells in dual-rate memory mode the read polarity picks which clock edge feeds the synchronising register.
// - cell registers start from a configured set or clear value and leave reset holding it.
// - bottom-edge cells carry an eight-wide gearbox working as 1:7, one 1:8, or two 1:4.
// - 1:7 words sit on bits 6..0, 1:8 words on 7..0, and each 1:4 word on its own half.
// - read polarity is found at the first rising strobe edge after the low preamble.
module ioc_cell #(
  parameter bit RIGHT_EDGE = 1'b1,               // memory strobe support present
  parameter bit BOTTOM_EDGE = 1'b1,              // gearbox and dynamic delay present
  parameter bit INIT_SET = ioc_pkg::INIT_DEFAULT // configured initial value
) (
  input wire logic pclk,                         // system clock, 100 MHz
  input wire logic presetn,                      // async reset, active low
  input wire logic psel,                         // apb select
  input wire logic penable,                      // apb access phase
  input wire logic pwrite,                       // apb direction
  input wire logic [11:0] paddr,                 // apb byte address
  input wire logic [31:0] pwdata,                // apb write data
  output logic [31:0] prdata,                    // apb read data
  output logic pready,                           // apb ready
  output logic pslverr,                          // apb error on unmapped address
  input wire logic pad_in,                       // pad input level
  input wire logic pad_pair_in,                  // partner pad of the pair
  output logic pad_out,                          // pad output level
  output logic buffer_output_enable,             // pad drive enable, high drives
  output logic bypass_comb_input,                // raw pad to core
  output logic bypass_clock_input,               // raw pad as clock
  input wire logic core_out_data_first,          // core data, both rates
  input wire logic core_out_data_second,         // core data, dual rate only
  input wire logic core_output_enable,           // core output enable
  input wire logic memory_mode_enable_in,        // memory mode select
  input wire logic clock_enable,                 // cell register enable
  input wire logic local_set_reset,              // force initial value
  input wire logic [4:0] dynamic_delay_select,   // run-time delay tap
  input wire logic strobe_read_clock_shifted,    // shifted read strobe
  input wire logic strobe_write_clock_shifted,   // shifted write strobe
  output logic read_polarity_select,             // found read polarity
  output logic rise_capture_out,                 // first captured output
  output logic fall_capture_out,                 // second captured output
  output logic capture_valid,                    // pair available
  input wire logic capture_ready,                // core takes the pair
  input wire logic word_align_request,           // gearbox slip request
  output logic [7:0] gear_word,                  // gearbox parallel word
  output logic gear_word_valid                   // one-cycle word strobe
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic s1, s2, p1, p2;
    logic r1, r2, r3;
    logic w1, w2, w3;
    logic [ioc_pkg::DLY_TAPS-1:0] line;
    logic rise_hold;
    logic oe_reg;
    logic mem_oe;
    logic pad_q;
    logic phase;
    logic pol;
    ioc_pkg::ioc_pol_t pst;
  } ioc_cell_st_t;

  typedef struct packed {
    logic n1;
    logic n2;
  } ioc_neg_st_t;

  ioc_cell_st_t st;
  ioc_cell_st_t next_st;
  ioc_neg_st_t ng;
  ioc_neg_st_t next_ng;
  logic dbit;
  logic ddr;
  logic mem_sel;
  logic hold_ok;
  logic wr_rise;
  logic rd_rise;
  logic sel_rise;
  logic sel_fall;
  ioc_pkg::ioc_dly_t dly_mode;
  ioc_stream_if #(.W(2)) cap_if ();
  ioc_stream_if #(.W(2)) core_if ();
  ioc_gear_if gear_if ();

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == ioc_pkg::ADDR_CTRL) || (a == ioc_pkg::ADDR_STATUS) || (a == ioc_pkg::ADDR_GEAR);
  endfunction : addr_ok

  // bypass path skips every flop, so it carries pad glitches too
  assign bypass_comb_input = pad_in;
  assign bypass_clock_input = pad_in;

  // decoded control
  assign ddr = st.ctrl[ioc_pkg::CTRL_DDR];
  assign dly_mode = ioc_pkg::ioc_dly_t'(st.ctrl[ioc_pkg::CTRL_DLY_LO +: 2]);
  assign mem_sel = RIGHT_EDGE && memory_mode_enable_in;
  assign hold_ok = clock_enable && !local_set_reset;
  assign wr_rise = RIGHT_EDGE && st.w2 && !st.w3;
  assign rd_rise = RIGHT_EDGE && st.r2 && !st.r3;

  // delay select: none, fixed tap, or a run-time tap on bottom cells
  always_comb begin
    case (dly_mode)
      ioc_pkg::DLY_FIXED: dbit = st.line[ioc_pkg::DLY_FIXED_CYC-1];
      ioc_pkg::DLY_DYNAMIC: dbit = BOTTOM_EDGE ? st.line[dynamic_delay_select] : st.s2;
      default: dbit = st.s2;
    endcase
  end

  // locked read polarity swaps which edge feeds the synchroniser
  always_comb begin
    if (mem_sel && st.pol) begin
      sel_rise = ng.n2;
      sel_fall = st.rise_hold;
    end else begin
      sel_rise = st.rise_hold;
      sel_fall = ng.n2;
    end
  end

  // pairs enter the buffer every clock-enabled cycle without local set/reset; full buffer stalls capture
  assign cap_if.valid = hold_ok;
  assign cap_if.data = ddr ? {sel_rise, sel_fall} : {st.rise_hold, st.rise_hold};

  ioc_pair_buffer #(.W(2)) u_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .fill(cap_if),
    .drain(core_if)
  );

  assign rise_capture_out = core_if.data[1];
  assign fall_capture_out = core_if.data[0];
  assign capture_valid = core_if.valid;
  assign core_if.ready = capture_ready;

  // gearbox fed from the delayed bit and the partner pad
  assign gear_if.bit_a = dbit;
  assign gear_if.bit_c = st.p2;
  assign gear_if.enable = BOTTOM_EDGE && st.ctrl[ioc_pkg::CTRL_GBX_EN];
  assign gear_if.align = word_align_request;
  assign gear_if.mode = ioc_pkg::ioc_gbx_t'(st.ctrl[ioc_pkg::CTRL_GBX_LO +: 2]);
  assign gear_word = gear_if.word;
  assign gear_word_valid = gear_if.word_valid;

  ioc_gearbox u_gearbox (
    .pclk(pclk),
    .presetn(presetn),
    .gp(gear_if)
  );

  // pad side and apb answers
  assign pad_out = st.pad_q;
  assign buffer_output_enable = mem_sel ? st.mem_oe : st.oe_reg;
  assign read_polarity_select = st.pol;
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  // falling-edge sampler; its first flop feeds only the second
  always_comb begin
    next_ng.n1 = pad_in;
    next_ng.n2 = ng.n1;
  end

  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      ng <= {INIT_SET, INIT_SET};
    end else begin
      ng <= next_ng;
    end
  end

  // rising-edge state of the cell
  always_comb begin
    next_st = st;
    // pin synchronisers
    next_st.s1 = pad_in;
    next_st.s2 = st.s1;
    next_st.p1 = pad_pair_in;
    next_st.p2 = st.p1;
    next_st.r1 = strobe_read_clock_shifted;
    next_st.r2 = st.r1;
    next_st.r3 = st.r2;
    next_st.w1 = strobe_write_clock_shifted;
    next_st.w2 = st.w1;
    next_st.w3 = st.w2;
    // delay line runs freely so a tap change sees settled data
    next_st.line = {st.line[ioc_pkg::DLY_TAPS-2:0], st.s2};
    next_st.phase = ~st.phase;
    // apb: read data latched in setup, write taken in access
    if (psel && !penable) begin
      case (paddr)
        ioc_pkg::ADDR_CTRL: next_st.rdata = st.ctrl;
        ioc_pkg::ADDR_STATUS: begin
          next_st.rdata = 32'h00000000;
          next_st.rdata[ioc_pkg::STAT_POL] = st.pol;
          next_st.rdata[ioc_pkg::STAT_PST_LO +: 2] = st.pst;
          next_st.rdata[ioc_pkg::STAT_OE] = buffer_output_enable;
          next_st.rdata[ioc_pkg::STAT_VALID] = core_if.valid;
          next_st.rdata[ioc_pkg::STAT_RISE] = core_if.data[1];
          next_st.rdata[ioc_pkg::STAT_FALL] = core_if.data[0];
        end
        ioc_pkg::ADDR_GEAR: next_st.rdata = {23'h000000, gear_if.word_valid, gear_if.word};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite && paddr == ioc_pkg::ADDR_CTRL) begin
      next_st.ctrl = pwdata & ioc_pkg::CTRL_MASK;
    end
    // cell registers: set/reset wins, clock enable low holds
    if (local_set_reset) begin
      next_st.rise_hold = INIT_SET;
      next_st.oe_reg = INIT_SET;
      next_st.mem_oe = INIT_SET;
      next_st.pad_q = INIT_SET;
    end else if (clock_enable) begin
      if (cap_if.ready) begin
        next_st.rise_hold = dbit;
      end
      next_st.oe_reg = core_output_enable;
      if (wr_rise) begin
        next_st.mem_oe = st.oe_reg;
      end
      // second data word only used in dual-rate, on the odd phase
      next_st.pad_q = (ddr && st.phase) ? core_out_data_second : core_out_data_first;
    end
    // read polarity search, restarted whenever memory mode drops
    case (st.pst)
      ioc_pkg::POL_IDLE: begin
        if (mem_sel && !st.r2) begin
          next_st.pst = ioc_pkg::POL_PREAMBLE;
        end
      end
      ioc_pkg::POL_PREAMBLE: begin
        if (!mem_sel) begin
          next_st.pst = ioc_pkg::POL_IDLE;
        end else if (rd_rise) begin
          next_st.pst = ioc_pkg::POL_LOCKED;
          next_st.pol = st.phase;
        end
      end
      ioc_pkg::POL_LOCKED: begin
        if (!mem_sel) begin
          next_st.pst = ioc_pkg::POL_IDLE;
        end
      end
      default: next_st.pst = ioc_pkg::POL_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctrl <= ioc_pkg::CTRL_RESET;
      st.rise_hold <= INIT_SET;
      st.oe_reg <= INIT_SET;
      st.mem_oe <= INIT_SET;
      st.pad_q <= INIT_SET;
      st.pst <= ioc_pkg::POL_IDLE;
      // strobes idle at their pull-up level; a zero here would fake a rise and a lock
      {st.r1, st.r2, st.r3, st.w1, st.w2, st.w3} <= 6'h3F;
    end else begin
      st <= next_st;
    end
  end

  // the release edge itself still resets the flop, so it is left out
  property p_oe_follows_core;
    @(posedge pclk) disable iff (!presetn)
    presetn && hold_ok |=> st.oe_reg == $past(core_output_enable);
  endproperty
  a_oe_follows_core: assert property (p_oe_follows_core)
    else $error("enable flop missed the core enable");

  property p_set_reset_init;
    @(posedge pclk) disable iff (!presetn)
    local_set_reset |=> st.oe_reg == INIT_SET && st.rise_hold == INIT_SET && pad_out == INIT_SET;
  endproperty
  a_set_reset_init: assert property (p_set_reset_init)
    else $error("set/reset did not force the initial value");

  property p_ce_low_holds;
    @(posedge pclk) disable iff (!presetn)
    !clock_enable && !local_set_reset |=> $stable(st.oe_reg) && $stable(st.rise_hold) && $stable(pad_out);
  endproperty
  a_ce_low_holds: assert property (p_ce_low_holds)
    else $error("cell register moved with clock enable low");

  property p_sdr_pair_same;
    @(posedge pclk) disable iff (!presetn)
    cap_if.valid && cap_if.ready && !ddr |-> cap_if.data[1] == cap_if.data[0];
  endproperty
  a_sdr_pair_same: assert property (p_sdr_pair_same)
    else $error("single-rate pair halves differ");

  property p_fixed_delay;
    @(posedge pclk) disable iff (!presetn)
    dly_mode == ioc_pkg::DLY_FIXED |-> dbit == $past(st.s2, ioc_pkg::DLY_FIXED_CYC);
  endproperty
  a_fixed_delay: assert property (p_fixed_delay)
    else $error("fixed delay tap off");

  property p_mem_oe_strobe_only;
    @(posedge pclk) disable iff (!presetn)
    !wr_rise && !local_set_reset |=> $stable(st.mem_oe);
  endproperty
  a_mem_oe_strobe_only: assert property (p_mem_oe_strobe_only)
    else $error("memory enable moved without a write strobe edge");

  property p_preamble_lock;
    @(posedge pclk) disable iff (!presetn)
    st.pst == ioc_pkg::POL_PREAMBLE && mem_sel && rd_rise |=> st.pst == ioc_pkg::POL_LOCKED && st.pol == $past(st.phase);
  endproperty
  a_preamble_lock: assert property (p_preamble_lock)
    else $error("polarity not locked on first strobe rise");

  property p_other_edge_quiet;
    @(posedge pclk) disable iff (!presetn)
    !RIGHT_EDGE |-> st.pst == ioc_pkg::POL_IDLE && buffer_output_enable == st.oe_reg;
  endproperty
  a_other_edge_quiet: assert property (p_other_edge_quiet)
    else $error("strobe logic active on a non-right cell");
endmodule : ioc_cell

// ### src/ioc_gearbox.sv
module ioc_gearbox (
  input wire logic pclk,      // system clock
  input wire logic presetn,   // async reset, active low
  ioc_gear_if.gear gp         // serial in, words out
);
  typedef struct packed {
    logic [7:0] sh_a;
    logic [3:0] sh_c;
    logic [3:0] cnt;
    logic [7:0] word;
    logic valid;
  } ioc_gear_t;

  ioc_gear_t st;
  ioc_gear_t next_st;

  function automatic logic [3:0] word_len(input ioc_pkg::ioc_gbx_t m);
    case (m)
      ioc_pkg::GBX_QUAD: word_len = ioc_pkg::LEN_QUAD;
      ioc_pkg::GBX_DUAL4: word_len = ioc_pkg::LEN_DUAL4;
      default: word_len = ioc_pkg::LEN_DESER7;
    endcase
  endfunction : word_len

  assign gp.word = st.word;
  assign gp.word_valid = st.valid;

  // align holds the count for every cycle it is high, slipping the word boundary one bit per cycle
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    if (gp.enable) begin
      next_st.sh_a = {st.sh_a[6:0], gp.bit_a};
      next_st.sh_c = {st.sh_c[2:0], gp.bit_c};
      if (!gp.align) begin
        next_st.cnt = 4'(st.cnt + 4'h1);
      end
      if (!gp.align && next_st.cnt >= word_len(gp.mode)) begin
        next_st.cnt = 4'h0;
        next_st.valid = 1'b1;
        case (gp.mode)
          ioc_pkg::GBX_QUAD: next_st.word = next_st.sh_a;
          ioc_pkg::GBX_DUAL4: next_st.word = {next_st.sh_a[3:0], next_st.sh_c};
          default: next_st.word = {1'b0, next_st.sh_a[6:0]};
        endcase
      end
    end else begin
      next_st.cnt = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_deser7_top_clear;
    @(posedge pclk) disable iff (!presetn)
    gp.word_valid && $past(gp.mode) == ioc_pkg::GBX_DESER7 |-> gp.word[7] == 1'b0;
  endproperty
  a_deser7_top_clear: assert property (p_deser7_top_clear)
    else $error("seven-bit word has bit 7 set");

  property p_word_spacing;
    @(posedge pclk) disable iff (!presetn)
    gp.word_valid |=> !gp.word_valid [*3];
  endproperty
  a_word_spacing: assert property (p_word_spacing)
    else $error("gearbox words closer than four bits");
endmodule : ioc_gearbox

// ### src/ioc_if.sv
// captured pairs travelling through the elastic buffer
interface ioc_stream_if #(parameter int W = 2);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ioc_stream_if

// serial bits in, parallel words out of the gearbox
interface ioc_gear_if;
  logic bit_a;
  logic bit_c;
  logic enable;
  logic align;
  ioc_pkg::ioc_gbx_t mode;
  logic [7:0] word;
  logic word_valid;
  modport host (output bit_a, output bit_c, output enable, output align, output mode,
                input word, input word_valid);
  modport gear (input bit_a, input bit_c, input enable, input align, input mode,
                output word, output word_valid);
endinterface : ioc_gear_if

// ### src/ioc_pair_buffer.sv
module ioc_pair_buffer #(
  parameter int W = 2
) (
  input wire logic pclk,      // system clock
  input wire logic presetn,   // async reset, active low
  ioc_stream_if.snk fill,     // from the capture stage
  ioc_stream_if.src drain     // to the core
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } ioc_buf_t;

  ioc_buf_t st;
  ioc_buf_t next_st;
  logic push;
  logic pop;

  // honest flags; full stalls the capture stage upstream
  assign fill.ready = (st.cnt != 2'h2);
  assign drain.valid = (st.cnt != 2'h0);
  assign drain.data = st.mem[st.rp];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // two entries let a one-cycle stall pass without a bubble
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = fill.data;
      next_st.wp = ~st.wp;
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end
    next_st.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : ioc_pair_buffer

// ### src/ioc_pkg.sv
package ioc_pkg;
  // register byte addresses on the apb side
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_GEAR = 12'h008;
  // control register fields
  localparam int CTRL_DDR = 0;
  localparam int CTRL_DLY_LO = 1;
  localparam int CTRL_GBX_LO = 3;
  localparam int CTRL_GBX_EN = 5;
  localparam logic [31:0] CTRL_MASK = 32'h0000003F;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // status and gear register fields
  localparam int STAT_POL = 0;
  localparam int STAT_PST_LO = 1;
  localparam int STAT_OE = 3;
  localparam int STAT_VALID = 4;
  localparam int STAT_RISE = 5;
  localparam int STAT_FALL = 6;
  localparam int GEAR_VALID = 8;
  // delay line and timing
  localparam int DLY_FIXED_CYC = 2;
  localparam int DLY_TAPS = 32;
  localparam logic INIT_DEFAULT = 1'b0;
  localparam logic [3:0] LEN_DESER7 = 4'h7;
  localparam logic [3:0] LEN_QUAD = 4'h8;
  localparam logic [3:0] LEN_DUAL4 = 4'h4;

  typedef enum logic [1:0] {DLY_NONE = 2'b00, DLY_FIXED = 2'b01, DLY_DYNAMIC = 2'b10} ioc_dly_t;
  typedef enum logic [1:0] {GBX_DESER7 = 2'b00, GBX_QUAD = 2'b01, GBX_DUAL4 = 2'b10} ioc_gbx_t;
  typedef enum logic [1:0] {POL_IDLE = 2'b00, POL_PREAMBLE = 2'b01, POL_LOCKED = 2'b10} ioc_pol_t;
endpackage : ioc_pkg

// ### tb/ioc_cell_tb_top.sv
module ioc_cell_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam bit INIT = 1'b1; // set flavour, unlike the zero reset flags
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pad_in, pad_pair_in, pad_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic buffer_output_enable, bypass_comb_input, bypass_clock_input, core_out_data_first;
  logic core_out_data_second, core_output_enable, memory_mode_enable_in, clock_enable;
  logic local_set_reset, strobe, read_polarity_select, rise_capture_out, fall_capture_out;
  logic capture_valid, capture_ready, word_align_request, gear_word_valid, err, ddr_wave, level;
  logic pair_level, strobe_run;
  logic [4:0] dynamic_delay_select;
  logic [7:0] gear_word;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int k;
  ioc_pkg::ioc_gbx_t gm[3] = '{ioc_pkg::GBX_DESER7, ioc_pkg::GBX_QUAD, ioc_pkg::GBX_DUAL4};
  logic [3:0] gl[3] = '{ioc_pkg::LEN_DESER7, ioc_pkg::LEN_QUAD, ioc_pkg::LEN_DUAL4};
  logic [7:0] gw[3] = '{8'h7F, 8'hFF, 8'hF0};

  ioc_cell #(.INIT_SET(INIT)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pad_in, .pad_pair_in, .pad_out, .buffer_output_enable, .bypass_comb_input, .bypass_clock_input,
    .core_out_data_first, .core_out_data_second, .core_output_enable, .memory_mode_enable_in,
    .clock_enable, .local_set_reset, .dynamic_delay_select, .strobe_read_clock_shifted(strobe),
    .strobe_write_clock_shifted(strobe), .read_polarity_select, .rise_capture_out, .fall_capture_out,
    .capture_valid, .capture_ready, .word_align_request, .gear_word, .gear_word_valid
  );
  ioc_pad_model far (
    .pclk, .ddr_wave, .level, .pair_level, .strobe_run, .pad_in, .pad_pair_in, .strobe_out(strobe)
  );

  // system clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // step off the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick

  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready high ends this wait; failing that, the hang guard does
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // cycles between two word strobes, align held high for the first al of them
  task automatic gap(output int n, input int al);
    for (n = 0; n < 40 && gear_word_valid !== 1'b1; n++) tick(1);
    for (n = 1; n < 40; n++) begin
      word_align_request <= (n <= al);
      tick(1);
      if (gear_word_valid === 1'b1) break;
    end
    word_align_request <= 1'b0;
  endtask : gap

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, core_out_data_first, core_out_data_second} = '0;
    {core_output_enable, memory_mode_enable_in, local_set_reset, dynamic_delay_select} = '0;
    {word_align_request, ddr_wave, level, pair_level, strobe_run} = '0;
    clock_enable = 1'b1;
    capture_ready = 1'b1;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    chk("oe_reset", buffer_output_enable, INIT);
    chk("pad_reset", pad_out, INIT);
    presetn <= 1'b1;
    // read-only, mask and unmapped accesses
    apb(1'b1, ioc_pkg::ADDR_GEAR, 32'hFFFFFFFF);
    apb(1'b0, ioc_pkg::ADDR_GEAR, '0);
    chk("gear_ro", rd, '0);
    apb(1'b1, ioc_pkg::ADDR_CTRL, 32'hFFFFFFFF);
    apb(1'b0, ioc_pkg::ADDR_CTRL, '0);
    chk("ctrl", rd, ioc_pkg::CTRL_MASK);
    apb(1'b0, 12'h00C, '0);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, '0);
    apb(1'b1, ioc_pkg::ADDR_CTRL, ioc_pkg::CTRL_RESET);
    $display("test registers done");
    // bypass and single-rate capture
    level <= 1'b1;
    tick(1);
    chk("comb", bypass_comb_input, 1'b1);
    chk("clkin", bypass_clock_input, 1'b1);
    tick(8);
    chk("sdr_rise", rise_capture_out, 1'b1);
    chk("sdr_fall", fall_capture_out, 1'b1);
    // fixed delay: a pad edge reaches the core two cycles later than undelayed
    apb(1'b1, ioc_pkg::ADDR_CTRL, 32'h00000002);
    level <= 1'b0;
    tick(5);
    chk("dly_fix_old", rise_capture_out, 1'b1);
    tick(1);
    chk("dly_fix_new", rise_capture_out, 1'b0);
    // run-time tap 4: five cycles later than undelayed
    apb(1'b1, ioc_pkg::ADDR_CTRL, 32'h00000004);
    dynamic_delay_select <= 5'h04;
    level <= 1'b1;
    tick(8);
    chk("dly_dyn_old", rise_capture_out, 1'b0);
    tick(1);
    chk("dly_dyn_new", rise_capture_out, 1'b1);
    // dual-rate: high before rising edges, low before falling edges
    apb(1'b1, ioc_pkg::ADDR_CTRL, 32'h00000001);
    ddr_wave <= 1'b1;
    tick(8);
    chk("ddr_rise", rise_capture_out, 1'b1);
    chk("ddr_fall", fall_capture_out, 1'b0);
    // core stalls: the buffered pair must survive
    capture_ready <= 1'b0;
    ddr_wave <= 1'b0;
    level <= 1'b0;
    tick(10);
    chk("held_valid", capture_valid, 1'b1);
    chk("held_rise", rise_capture_out, 1'b1);
    chk("held_fall", fall_capture_out, 1'b0);
    capture_ready <= 1'b1;
    tick(8);
    chk("new_rise", rise_capture_out, 1'b0);
    clock_enable <= 1'b0;
    level <= 1'b1;
    tick(8);
    chk("frozen", capture_valid, 1'b0);
    clock_enable <= 1'b1;
    $display("test capture done");
    // single-rate output enable and local set
    apb(1'b1, ioc_pkg::ADDR_CTRL, ioc_pkg::CTRL_RESET);
    core_out_data_first <= 1'b1;
    core_output_enable <= 1'b0;
    tick(2);
    chk("oe_low", buffer_output_enable, 1'b0);
    chk("pad_data", pad_out, 1'b1);
    local_set_reset <= 1'b1;
    tick(2);
    chk("oe_set", buffer_output_enable, INIT);
    local_set_reset <= 1'b0;
    core_output_enable <= 1'b1;
    tick(2);
    chk("oe_high", buffer_output_enable, 1'b1);
    // memory mode: enable moves only on a write strobe rise
    core_output_enable <= 1'b0;
    memory_mode_enable_in <= 1'b1;
    strobe_run <= 1'b1;
    tick(12);
    chk("mem_oe0", buffer_output_enable, 1'b0);
    strobe_run <= 1'b0;
    tick(8);
    core_output_enable <= 1'b1;
    tick(8);
    chk("mem_hold", buffer_output_enable, 1'b0);
    strobe_run <= 1'b1;
    tick(12);
    chk("mem_oe1", buffer_output_enable, 1'b1);
    apb(1'b0, ioc_pkg::ADDR_STATUS, '0);
    chk("pol_state", rd[2:1], ioc_pkg::POL_LOCKED);
    chk("stat_oe", rd[ioc_pkg::STAT_OE], 1'b1);
    chk("pol_out", read_polarity_select, rd[ioc_pkg::STAT_POL]);
    $display("test enable done");
    // gearbox in every mode, steady 1 on the pad, 0 on its partner
    memory_mode_enable_in <= 1'b0;
    strobe_run <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ioc_pkg::ADDR_CTRL, ioc_pkg::CTRL_RESET);
      apb(1'b1, ioc_pkg::ADDR_CTRL, 32'h20 | (32'(gm[i]) << ioc_pkg::CTRL_GBX_LO));
      gap(k, 0);
      chk("gap", k, gl[i]);
      chk("word", gear_word, gw[i]);
    end
    apb(1'b1, ioc_pkg::ADDR_CTRL, 32'h20 | (32'(ioc_pkg::GBX_QUAD) << ioc_pkg::CTRL_GBX_LO));
    gap(k, 0);
    gap(k, 3);
    chk("align_gap", k, 32'(ioc_pkg::LEN_QUAD) + 3);
    apb(1'b0, ioc_pkg::ADDR_GEAR, '0);
    chk("gear_reg", rd[7:0], 8'hFF);
    $display("test gearbox done");
    test_done();
  end
endmodule : ioc_cell_tb_top

// ### tb/ioc_pad_model.sv
module ioc_pad_model (
  input wire logic pclk,        // system clock
  input wire logic ddr_wave,    // pad low in first half, high in second
  input wire logic level,       // steady pad level
  input wire logic pair_level,  // partner pad level
  input wire logic strobe_run,  // memory burst in progress
  output logic pad_in,          // pad level to the cell
  output logic pad_pair_in,     // partner pad to the cell
  output logic strobe_out       // shifted strobe, read and write alike
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph;
  // pad follows the clock halves so rise and fall samples differ
  always @(pclk or ddr_wave or level) pad_in <= ddr_wave ? !pclk : level;
  assign pad_pair_in = pair_level;
  // strobe parks high between bursts, as the termination would pull it;
  // each burst opens with a two-cycle low preamble, then toggles slowly
  always @(posedge pclk) begin
    ph <= strobe_run ? ph + 3'h1 : 3'h0;
    strobe_out <= !strobe_run || (ph >= 3'h2 && ph[1]);
  end
endmodule : ioc_pad_model
